/* File: testbench/civr_engine_model.sv */
// Behavioural model of the protocol engine that raises buffer events.
module civr_engine_model (
    // Clock
    input wire logic pclk,
    // Events towards the block
    output civr_pkg::civr_evt_t evt
);
    timeunit 1ns;
    timeprecision 100ps;
    // Nothing is raised until the bench asks for it.
    initial evt = '0;
    // A buffer event is a one-cycle pulse with its filter index beside it.
    task automatic pulse(input int idx, input logic [4:0] filt);
        @(posedge pclk);
        evt.buf_event[idx] <= 1'b1;
        evt.filter_idx <= filt;
        @(posedge pclk);
        evt.buf_event <= 16'h0000;
        // The index is not valid between pulses, so it shows junk.
        evt.filter_idx <= ~filt;
    endtask
    // Error, wake-up and almost-full are levels that stand until changed.
    task automatic levels(input logic [2:0] lv);
        @(posedge pclk);
        {evt.error, evt.wakeup, evt.fifo_almost_full} <= lv;
    endtask
endmodule // civr_engine_model

/* File: testbench/civr_top_test.sv */
// Self-checking bench for the interrupt vector report block.
module civr_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, irq, rerr;
    civr_pkg::civr_evt_t evt;
    int err_total = 0;
    int n_compared = 0;
    // Half period of the 200 MHz clock.
    always #2.5 pclk = ~pclk;
    civr_top civr_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .evt(evt), .irq(irq));
    civr_engine_model civr_engine_model_inst (.pclk(pclk), .evt(evt));
    // Verdict and end of run.
    task automatic report_and_stop;
        if (err_total == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One APB transfer; the wait on pready is bounded so a hang ends the run.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdat = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 50) begin
            err_total++;
            report_and_stop();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask
    // The interrupt line is a registered level, so look one edge later.
    task automatic irq_is(input logic exp);
        @(posedge pclk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask
    // Reset state, and an unmapped address is refused.
    task automatic t_reset;
        rd(civr_pkg::ADDR_VEC, 32'h0040);
        rd(civr_pkg::ADDR_FLAG, 32'h0);
        rd(12'hff0, 32'h0);
        chk({31'h0, rerr}, 32'h1);
    endtask
    // Flags, lowest pending buffer first, filter field, read-only vector.
    task automatic t_buffers;
        civr_engine_model_inst.pulse(3, 5'h00);
        rd(civr_pkg::ADDR_FLAG, 32'h1);
        civr_engine_model_inst.pulse(9, 5'h0f);
        rd(civr_pkg::ADDR_FLAG, 32'h3);
        wr(civr_pkg::ADDR_VEC, 32'hffff);
        rd(civr_pkg::ADDR_VEC, 32'h0f03);
        wr(civr_pkg::ADDR_BUFP, 32'h8);
        rd(civr_pkg::ADDR_VEC, 32'h0f09);
        wr(civr_pkg::ADDR_FLAG, 32'h3);
        rd(civr_pkg::ADDR_FLAG, 32'h0);
    endtask
    // Error over wake-up over almost-full over buffers, then no source.
    task automatic t_levels;
        logic [2:0] lv [4] = '{3'b111, 3'b011, 3'b001, 3'b000};
        logic [6:0] cd [4] = '{7'h41, 7'h42, 7'h44, 7'h09};
        for (int i = 0; i < 4; i++) begin
            civr_engine_model_inst.levels(lv[i]);
            rd(civr_pkg::ADDR_VEC, {19'h0, 5'h0f, 1'b0, cd[i]});
        end
        wr(civr_pkg::ADDR_BUFP, 32'h200);
        rd(civr_pkg::ADDR_VEC, 32'h0f40);
    endtask
    // Interrupt raised, masked and cleared.
    task automatic t_irq;
        wr(civr_pkg::ADDR_MASK, 32'h1);
        civr_engine_model_inst.pulse(0, 5'h00);
        irq_is(1'b1);
        wr(civr_pkg::ADDR_MASK, 32'h2);
        irq_is(1'b0);
        civr_engine_model_inst.pulse(12, 5'h01);
        irq_is(1'b1);
        rd(civr_pkg::ADDR_VEC, 32'h0100);
        wr(civr_pkg::ADDR_FLAG, 32'h2);
        irq_is(1'b0);
    endtask
    // Reset in mid-run clears all; a set meeting its clear wins.
    task automatic t_reset_mid;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        irq_is(1'b0);
        rd(civr_pkg::ADDR_VEC, 32'h0040);
        rd(civr_pkg::ADDR_FLAG, 32'h0);
        rd(civr_pkg::ADDR_MASK, 32'h0);
        civr_engine_model_inst.pulse(2, 5'h00);
        // The pulse is sampled at the same edge that takes the clear.
        fork
            wr(civr_pkg::ADDR_FLAG, 32'h1);
            begin
                @(posedge pclk);
                civr_engine_model_inst.pulse(2, 5'h00);
            end
        join
        rd(civr_pkg::ADDR_FLAG, 32'h1);
        rd(civr_pkg::ADDR_VEC, 32'h0002);
    endtask
    // Reset for eight cycles, then the scenarios in turn.
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_buffers();
        t_levels();
        t_irq();
        t_reset_mid();
        report_and_stop();
    end
endmodule // civr_top_test

/* File: verilog/civr_pkg.sv */
// Constants and types shared by the interrupt vector report logic.
package civr_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_VEC = 12'h000;
    localparam logic [11:0] ADDR_FLAG = 12'h004;
    localparam logic [11:0] ADDR_MASK = 12'h008;
    localparam logic [11:0] ADDR_BUFP = 12'h00c;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int TX_FLAG_BIT = 0;
    localparam int RX_FLAG_BIT = 1;
    localparam int NUM_BUF = 16;
    localparam int NUM_TX_BUF = 8;
    localparam int FILT_LSB = 8;
    localparam int CODE_W = 7;
    localparam int FILT_W = 5;

    // ------------------------------------------------------------
    // Source codes
    // ------------------------------------------------------------
    localparam logic [6:0] CODE_NONE = 7'h40;
    localparam logic [6:0] CODE_ERROR = 7'h41;
    localparam logic [6:0] CODE_WAKE = 7'h42;
    localparam logic [6:0] CODE_FIFO_AF = 7'h44;
    localparam logic [4:0] FILT_RESET = 5'h00;

    // Event carrier from the protocol engine.
    typedef struct packed {
        logic [15:0] buf_event;
        logic [4:0] filter_idx;
        logic error;
        logic wakeup;
        logic fifo_almost_full;
    } civr_evt_t;
endpackage

/* File: verilog/civr_top.sv */
// Interrupt vector and buffer interrupt flag logic with an APB slave.
//
// What this block does
// - Read-only vector holds matched filter index.
// - Seven-bit code reports the pending source.
// - Receive buffer flag sits at bit one.
// - Transmit buffer flag sits at bit zero.
// - Flag reads one after its request.
// - Flag reads zero without a request.
//
// The implementer's own choices: the register addresses and the APB register port.
module civr_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Protocol engine events
    input wire civr_pkg::civr_evt_t evt,
    // Interrupt
    output logic irq
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic wr_en;
    logic hit;
    logic [1:0] flag_reg, flag_next;
    logic [1:0] mask_reg, mask_next;
    logic [15:0] bufp_reg, bufp_next;
    logic [4:0] filt_reg, filt_next;
    logic [6:0] code_reg, code_next;
    logic [15:0] vec_word;
    logic [31:0] rd_word;
    logic [31:0] prdata_reg, prdata_next;
    logic irq_reg, irq_next;

    // Zero wait states keep the master simple; every access ends at once.
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign hit = (paddr == civr_pkg::ADDR_VEC) |
                 (paddr == civr_pkg::ADDR_FLAG) |
                 (paddr == civr_pkg::ADDR_MASK) |
                 (paddr == civr_pkg::ADDR_BUFP);
    assign pslverr = psel & penable & ~hit;

    assign vec_word = {3'h0, filt_reg, 1'b0, code_reg};

    // Read mux; unmapped addresses read zero.
    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            civr_pkg::ADDR_VEC: rd_word = {16'h0000, vec_word};
            civr_pkg::ADDR_FLAG: rd_word = {30'h0, flag_reg};
            civr_pkg::ADDR_MASK: rd_word = {30'h0, mask_reg};
            civr_pkg::ADDR_BUFP: rd_word = {16'h0000, bufp_reg};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Read data is captured in the setup cycle so that it leaves from a
    // register and stands through the access phase. A flag that changes
    // during the access cycle shows on the next read instead.
    always_comb begin
        prdata_next = prdata_reg;
        if (psel && !penable && !pwrite) begin
            prdata_next = rd_word;
        end
    end

    // ------------------------------------------------------------
    // Flags, pending buffers and vector
    // ------------------------------------------------------------
    logic tx_set;
    logic rx_set;
    logic [1:0] flag_clr;
    logic [15:0] bufp_clr;

    assign tx_set = |evt.buf_event[civr_pkg::NUM_TX_BUF-1:0];
    assign rx_set = |evt.buf_event[civr_pkg::NUM_BUF-1:civr_pkg::NUM_TX_BUF];
    assign flag_clr = (wr_en && paddr == civr_pkg::ADDR_FLAG) ?
                      pwdata[1:0] : 2'b00;
    assign bufp_clr = (wr_en && paddr == civr_pkg::ADDR_BUFP) ?
                      pwdata[15:0] : 16'h0000;

    // Next state; a set arriving with a clear wins so no event is lost.
    always_comb begin
        flag_next = flag_reg;
        mask_next = mask_reg;
        bufp_next = (bufp_reg & ~bufp_clr) | evt.buf_event;
        filt_next = filt_reg;
        flag_next[civr_pkg::TX_FLAG_BIT] =
            (flag_reg[civr_pkg::TX_FLAG_BIT] &
             ~flag_clr[civr_pkg::TX_FLAG_BIT]) | tx_set;
        flag_next[civr_pkg::RX_FLAG_BIT] =
            (flag_reg[civr_pkg::RX_FLAG_BIT] &
             ~flag_clr[civr_pkg::RX_FLAG_BIT]) | rx_set;
        if (wr_en && paddr == civr_pkg::ADDR_MASK) begin
            mask_next = pwdata[1:0];
        end
        if (rx_set) begin
            filt_next = evt.filter_idx;
        end
        code_next = civr_pkg::CODE_NONE;
        if (evt.error) begin
            code_next = civr_pkg::CODE_ERROR;
        end else if (evt.wakeup) begin
            code_next = civr_pkg::CODE_WAKE;
        end else if (evt.fifo_almost_full) begin
            code_next = civr_pkg::CODE_FIFO_AF;
        end else begin
            for (int i = civr_pkg::NUM_BUF - 1; i >= 0; i--) begin
                if (bufp_next[i]) begin
                    code_next = 7'(i);
                end
            end
        end
    end

    // Registers only; reset shows the no-interrupt code.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= 2'b00;
            mask_reg <= 2'b00;
            bufp_reg <= 16'h0000;
            filt_reg <= civr_pkg::FILT_RESET;
            code_reg <= civr_pkg::CODE_NONE;
            prdata_reg <= 32'h0000_0000;
            irq_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
            mask_reg <= mask_next;
            bufp_reg <= bufp_next;
            filt_reg <= filt_next;
            code_reg <= code_next;
            prdata_reg <= prdata_next;
            irq_reg <= irq_next;
        end
    end

    // flag raises interrupt when its mask bit is set
    // The level is built from next values, so it moves on the same edge as
    // the flags and the mask while still leaving from a register.
    assign irq_next = |(flag_next & mask_next);
    assign irq = irq_reg;
    assign prdata = prdata_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pwrite && paddr == civr_pkg::ADDR_VEC) |->
            prdata[31:13] == 19'h00000 && prdata[7] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("Reserved vector bits not zero.");

    property p_filt_capture;
        @(posedge pclk) disable iff (!presetn)
        rx_set |=> filt_reg == $past(evt.filter_idx);
    endproperty
    a_filt_capture: assert property (p_filt_capture)
        else $error("Filter index not captured.");

    property p_read_capture;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == civr_pkg::ADDR_VEC) |=>
            prdata[15:0] == $past(vec_word);
    endproperty
    a_read_capture: assert property (p_read_capture)
        else $error("Vector read data not captured.");

    property p_code_none;
        @(posedge pclk) disable iff (!presetn)
        (!evt.error && !evt.wakeup && !evt.fifo_almost_full &&
         bufp_next == 16'h0000) |=> code_reg == civr_pkg::CODE_NONE;
    endproperty
    a_code_none: assert property (p_code_none)
        else $error("No-interrupt code missing.");

    property p_code_low;
        @(posedge pclk) disable iff (!presetn)
        (!evt.error && !evt.wakeup && !evt.fifo_almost_full &&
         bufp_next[0]) |=> code_reg == 7'h00;
    endproperty
    a_code_low: assert property (p_code_low)
        else $error("Lowest buffer code not reported.");

    property p_rx_set;
        @(posedge pclk) disable iff (!presetn)
        rx_set |=> flag_reg[civr_pkg::RX_FLAG_BIT];
    endproperty
    a_rx_set: assert property (p_rx_set)
        else $error("Receive flag not set.");

    property p_tx_set;
        @(posedge pclk) disable iff (!presetn)
        tx_set |=> flag_reg[civr_pkg::TX_FLAG_BIT];
    endproperty
    a_tx_set: assert property (p_tx_set)
        else $error("Transmit flag not set.");

    property p_flag_hold;
        @(posedge pclk) disable iff (!presetn)
        (flag_reg[0] && !(flag_clr[0] && !tx_set)) |=> flag_reg[0];
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("Transmit flag dropped without clear.");

    property p_flag_zero;
        @(posedge pclk) disable iff (!presetn)
        (!flag_reg[1] && !rx_set) |=> !flag_reg[1];
    endproperty
    a_flag_zero: assert property (p_flag_zero)
        else $error("Receive flag set without request.");

    property p_flag_clear;
        @(posedge pclk) disable iff (!presetn)
        (flag_clr[civr_pkg::RX_FLAG_BIT] && !rx_set) |=>
            !flag_reg[civr_pkg::RX_FLAG_BIT];
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("Receive flag kept after clear.");

    property p_prio_error;
        @(posedge pclk) disable iff (!presetn)
        evt.error |=> code_reg == civr_pkg::CODE_ERROR;
    endproperty
    a_prio_error: assert property (p_prio_error)
        else $error("Error source not given priority.");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        irq == ((flag_reg[0] && mask_reg[0]) || (flag_reg[1] && mask_reg[1]));
    endproperty
    a_irq: assert property (p_irq)
        else $error("Interrupt output wrong.");
endmodule // civr_top
